// file: logic/chop_pkg.sv
package chop_pkg;

    // ======================================================================
    // Clock and timing
    // ======================================================================
    localparam int CLK_MHZ       = 200;
    localparam int OFF_TIME_NS   = 375;
    // Least time: round up to whole cycles
    localparam int OFF_TIME_CYC  = (OFF_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int LAMP_OUT_MS   = 2000;
    localparam int LAMP_OUT_CYC  = LAMP_OUT_MS * CLK_MHZ * 1000;
    localparam int OFF_CNT_W     = 7;
    localparam logic [OFF_CNT_W-1:0] OFF_CNT_LAST = OFF_CNT_W'(OFF_TIME_CYC - 1);

    // ======================================================================
    // Brightness code and chopping
    // ======================================================================
    localparam int CODE_W                = 5;
    localparam logic [CODE_W-1:0] CODE_MIN    = 5'h00;
    localparam logic [CODE_W-1:0] CODE_MAX    = 5'h1f;
    localparam logic [CODE_W-1:0] CODE_FLOOR  = 5'h03;
    localparam logic [CODE_W-1:0] BRIGHT_RST  = 5'h1f;
    localparam logic [7:0] CHOP_PERIOD   = 8'h80;   // Sync pulses per chopping period
    localparam logic [7:0] CHOP_MIN_ON   = 8'h0c;   // 12 of 128 pulses
    localparam logic [5:0] WEIGHT_FULL   = 6'h20;
    localparam logic [5:0] WEIGHT_ZERO   = 6'h00;

    // ======================================================================
    // Brightness converter
    // ======================================================================
    localparam int CTL_W              = 10;
    localparam logic [15:0] CTL_FS    = 16'h03ff;   // Control input equal to reference
    localparam logic [15:0] ADC_DIV   = 16'h0021;
    localparam logic [15:0] ADC_UP    = 16'h0002;
    localparam logic [15:0] ADC_DN    = 16'h001f;

    // ======================================================================
    // Register map (byte addresses) and fields
    // ======================================================================
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_BRIGHT = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int CTRL_SHDN_BIT      = 0;
    localparam int CTRL_CLR_BIT       = 1;

    typedef enum logic [1:0] {
        LVL_GND  = 2'b00,
        LVL_REF  = 2'b01,
        LVL_RAIL = 2'b11
    } pin_level_t;

    typedef enum logic [1:0] {
        BK_OFF   = 2'b00,
        BK_READY = 2'b01,
        BK_ON    = 2'b11
    } buck_state_t;

    typedef struct packed {
        logic [5:0] ref_weight;
        logic [5:0] min_weight;
    } cur_target_t;

    typedef struct packed {
        logic [20:0]       zero;
        logic              suspend;
        logic [1:0]        mode;
        logic              shutdown;
        logic              chop_on;
        logic              lamp_out;
        logic [CODE_W-1:0] code;
    } status_t;

endpackage : chop_pkg

// file: logic/chop_pwm_gen.sv
`timescale 1ns/10ps
module chop_pwm_gen
    import chop_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    input  wire logic              ce_in,
    input  wire logic              sync_pulse_in,
    input  wire logic              enable_in,
    input  wire logic [CODE_W-1:0] code_in,
    output logic                   on_out
);

    // ======================================================================
    // Period counter and on-time threshold
    // ======================================================================
    logic [6:0] cnt_q, cnt_d;
    logic [7:0] thr_q, thr_d;
    logic [7:0] thr_new;
    logic       on_q, on_d;

    // Codes up to the floor share the minimum duty; above it (code + 1) * 4 pulses
    always_comb begin
        if (code_in <= CODE_FLOOR) begin
            thr_new = CHOP_MIN_ON;
        end else begin
            thr_new = {1'b0, code_in, 2'b00} + 8'h04;
        end
    end

    // Threshold is only taken at a period boundary so a code change
    // cannot cut a pulse short or stretch it
    always_comb begin
        cnt_d = cnt_q;
        thr_d = thr_q;
        on_d  = on_q;
        if (sync_pulse_in) begin
            cnt_d = cnt_q + 7'h01;
            if (cnt_q == 7'h7f) begin
                thr_d = thr_new;
            end
        end
        if (!enable_in) begin
            on_d = 1'b1;
        end else begin
            on_d = ({1'b0, cnt_q} < thr_q);
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= 7'h00;
            thr_q <= CHOP_PERIOD;
            on_q  <= 1'b1;
        end else if (ce_in) begin
            cnt_q <= cnt_d;
            thr_q <= thr_d;
            on_q  <= on_d;
        end
    end

    assign on_out = on_q;

endmodule : chop_pwm_gen

// file: logic/bright_chop_ctrl.sv
`timescale 1ns/10ps
module bright_chop_ctrl
    import chop_pkg::*;
#(
    parameter int unsigned LAMP_OUT_CYCLES = LAMP_OUT_CYC
)
(
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    input  wire logic              ce_in,
    // Avalon-MM slave
    input  wire logic [3:0]        avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    output logic [31:0]            avs_readdata_out,
    output logic                   avs_waitrequest_out,
    // Pins, already decoded to logic levels
    input  wire pin_level_t        mode_level_in,
    input  wire logic              mode_sync_in,
    input  wire pin_level_t        min_level_in,
    input  wire logic              shutdown_suspend_n_in,
    input  wire logic [CTL_W-1:0]  ctl_ratio_in,
    input  wire logic              comm_sense_in,
    input  wire logic              pwm_trip_in,
    input  wire logic              cur_limit_in,
    input  wire logic              avg_sense_above_in,
    // Lamp side
    output logic                   chop_pwm_out,
    output logic                   regulate_en_out,
    output cur_target_t            cur_target_out,
    output logic [CODE_W-1:0]      code_out,
    output logic                   high_side_out,
    output logic                   lamp_out_flag_out
);

    // ======================================================================
    // Interface selection
    // ======================================================================
    logic digital_mode;
    logic neg_scale;
    logic shutdown;
    logic chop_en;
    logic chop_on;
    logic lamp_run;

    logic              ctrl_shdn_q, ctrl_shdn_d;
    logic [CODE_W-1:0] bright_q, bright_d;
    logic [CODE_W-1:0] adc_q, adc_d;
    logic [CODE_W-1:0] code;
    logic              lamp_out_q, lamp_out_d;
    logic              lamp_clr;

    // Mode pin level decides where the code comes from
    always_comb begin
        digital_mode = (mode_level_in == LVL_RAIL);
        neg_scale    = (mode_level_in == LVL_REF);
    end

    // In the serial mode the pin only sets the suspend status bit, so shutdown
    // there comes from the control register instead
    always_comb begin
        if (digital_mode) begin
            shutdown = ctrl_shdn_q;
        end else begin
            shutdown = !shutdown_suspend_n_in;
        end
    end

    assign code     = digital_mode ? bright_q : adc_q;
    assign chop_en  = (min_level_in != LVL_RAIL);
    assign lamp_run = !shutdown && !lamp_out_q;

    // ======================================================================
    // Brightness converter with one code of hysteresis
    // ======================================================================
    logic [15:0] ctl33;
    logic [15:0] code16;
    logic [15:0] up_thr;
    logic [15:0] dn_thr;

    assign ctl33  = 16'(ctl_ratio_in) * ADC_DIV;
    assign code16 = 16'(adc_q);

    // Thresholds scaled by the full-scale count so no divide is needed
    always_comb begin
        if (neg_scale) begin
            up_thr = (ADC_DIV - code16) * CTL_FS;
            dn_thr = (ADC_DN - code16) * CTL_FS;
        end else begin
            up_thr = (code16 + ADC_UP) * CTL_FS;
            dn_thr = code16 * CTL_FS;
        end
    end

    // One step per cycle; a large input jump walks the code over
    // up to 31 cycles, well below any visible flicker
    always_comb begin
        adc_d = adc_q;
        if (neg_scale) begin
            if ((ctl33 > up_thr) && (adc_q != CODE_MIN)) begin
                adc_d = adc_q - 5'h01;
            end else if ((ctl33 < dn_thr) && (adc_q != CODE_MAX)) begin
                adc_d = adc_q + 5'h01;
            end
        end else begin
            if ((ctl33 > up_thr) && (adc_q != CODE_MAX)) begin
                adc_d = adc_q + 5'h01;
            end else if ((ctl33 < dn_thr) && (adc_q != CODE_MIN)) begin
                adc_d = adc_q - 5'h01;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            adc_q <= CODE_MIN;
        end else if (ce_in) begin
            adc_q <= adc_d;
        end
    end

    // ======================================================================
    // Chopping generator
    // ======================================================================
    chop_pwm_gen u_chop (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .ce_in         (ce_in),
        .sync_pulse_in (mode_sync_in),
        .enable_in     (chop_en),
        .code_in       (code),
        .on_out        (chop_on)
    );

    // ======================================================================
    // Current target and lamp outputs
    // ======================================================================
    cur_target_t target_q, target_d;
    logic        chop_q, chop_d;

    always_comb begin
        unique case (min_level_in)
            LVL_RAIL: begin
                target_d.ref_weight = {1'b0, code};
                target_d.min_weight = WEIGHT_ZERO;
            end
            LVL_REF: begin
                target_d.ref_weight = WEIGHT_FULL;
                target_d.min_weight = WEIGHT_ZERO;
            end
            default: begin
                target_d.ref_weight = {1'b0, code};
                target_d.min_weight = WEIGHT_FULL - {1'b0, code};
            end
        endcase
        chop_d = lamp_run && chop_on;
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            target_q <= '0;
            chop_q   <= 1'b0;
        end else if (ce_in) begin
            target_q <= target_d;
            chop_q   <= chop_d;
        end
    end

    assign cur_target_out  = target_q;
    assign chop_pwm_out    = chop_q;
    // Loop is frozen during off-periods so it holds its on-period level
    assign regulate_en_out = chop_q;
    assign code_out        = code;

    // ======================================================================
    // Buck high-side gating
    // ======================================================================
    buck_state_t            bk_q, bk_d;
    logic [OFF_CNT_W-1:0]   off_cnt_q, off_cnt_d;
    logic                   comm_prev_q;
    logic                   fall_pend_q, fall_pend_d;
    logic                   comm_fall;

    assign comm_fall = comm_prev_q && !comm_sense_in;

    always_comb begin
        bk_d        = bk_q;
        off_cnt_d   = off_cnt_q;
        fall_pend_d = fall_pend_q || comm_fall;
        unique case (bk_q)
            BK_OFF: begin
                if (off_cnt_q == OFF_CNT_LAST) begin
                    bk_d = BK_READY;
                end else begin
                    off_cnt_d = off_cnt_q + 7'h01;
                end
            end
            BK_READY: begin
                if ((fall_pend_q || comm_fall) && chop_q) begin
                    bk_d        = BK_ON;
                    fall_pend_d = 1'b0;
                end
            end
            BK_ON: begin
                fall_pend_d = 1'b0;
                if (pwm_trip_in || cur_limit_in || !chop_q) begin
                    bk_d      = BK_OFF;
                    off_cnt_d = '0;
                end
            end
            default: begin
                bk_d      = BK_OFF;
                off_cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            bk_q        <= BK_OFF;
            off_cnt_q   <= '0;
            comm_prev_q <= 1'b0;
            fall_pend_q <= 1'b0;
        end else if (ce_in) begin
            bk_q        <= bk_d;
            off_cnt_q   <= off_cnt_d;
            comm_prev_q <= comm_sense_in;
            fall_pend_q <= fall_pend_d;
        end
    end

    assign high_side_out = (bk_q == BK_ON);

    // ======================================================================
    // Lamp-out watchdog
    // ======================================================================
    logic [31:0] lo_cnt_q, lo_cnt_d;
    logic        lo_hit;

    assign lo_hit = (lo_cnt_q == 32'(LAMP_OUT_CYCLES - 1)) && !avg_sense_above_in;

    // Trip wins over a clear in the same cycle; shutdown releases it
    always_comb begin
        lo_cnt_d   = lo_cnt_q;
        lamp_out_d = lamp_out_q;
        if (shutdown || avg_sense_above_in || lamp_out_q) begin
            lo_cnt_d = '0;
        end else begin
            lo_cnt_d = lo_cnt_q + 32'h1;
        end
        if (shutdown || lamp_clr) begin
            lamp_out_d = 1'b0;
        end
        if (lo_hit && !shutdown) begin
            lamp_out_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lo_cnt_q   <= '0;
            lamp_out_q <= 1'b0;
        end else if (ce_in) begin
            lo_cnt_q   <= lo_cnt_d;
            lamp_out_q <= lamp_out_d;
        end
    end

    assign lamp_out_flag_out = lamp_out_q;

    // ======================================================================
    // Avalon-MM register slave
    // ======================================================================
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        req;
    logic        wr_go;
    status_t     status;

    assign req   = avs_read_in || avs_write_in;
    // Write lands on the edge where waitrequest is low
    assign wr_go = avs_write_in && ack_q && avs_byteenable_in[0];

    always_comb begin
        status          = '0;
        status.code     = code;
        status.lamp_out = lamp_out_q;
        status.chop_on  = chop_q;
        status.shutdown = shutdown;
        status.mode     = mode_level_in;
        status.suspend  = digital_mode && !shutdown_suspend_n_in;
    end

    // Every access takes one wait cycle; read data is captured there
    always_comb begin
        ack_d       = req && !ack_q;
        rdata_d     = rdata_q;
        ctrl_shdn_d = ctrl_shdn_q;
        bright_d    = bright_q;
        lamp_clr    = 1'b0;
        if (avs_read_in && !ack_q) begin
            unique case (avs_address_in)
                REG_CTRL:   rdata_d = {31'h0, ctrl_shdn_q};
                REG_BRIGHT: rdata_d = {27'h0, bright_q};
                REG_STATUS: rdata_d = status;
                default:    rdata_d = 32'h0;
            endcase
        end
        if (wr_go && (avs_address_in == REG_CTRL)) begin
            ctrl_shdn_d = avs_writedata_in[CTRL_SHDN_BIT];
            lamp_clr    = avs_writedata_in[CTRL_CLR_BIT];
        end
        if (wr_go && (avs_address_in == REG_BRIGHT)) begin
            bright_d = avs_writedata_in[CODE_W-1:0];
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_q       <= 1'b0;
            rdata_q     <= '0;
            ctrl_shdn_q <= 1'b0;
            bright_q    <= BRIGHT_RST;
        end else if (ce_in) begin
            ack_q       <= ack_d;
            rdata_q     <= rdata_d;
            ctrl_shdn_q <= ctrl_shdn_d;
            bright_q    <= bright_d;
        end
    end

    assign avs_waitrequest_out = req && !ack_q;
    assign avs_readdata_out    = rdata_q;

endmodule : bright_chop_ctrl

// file: sim/bright_chop_props.sv
`timescale 1ns/10ps
module bright_chop_props
    import chop_pkg::*;
#(
    parameter int unsigned LAMP_OUT_CYCLES = LAMP_OUT_CYC
)
(
    input wire logic              mclk_in,
    input wire logic              rst_in,
    input wire logic              ce_in,
    input wire logic [3:0]        avs_address_in,
    input wire logic              avs_read_in,
    input wire logic              avs_write_in,
    input wire logic [31:0]       avs_writedata_in,
    input wire logic [3:0]        avs_byteenable_in,
    input wire logic [31:0]       avs_readdata_out,
    input wire logic              avs_waitrequest_out,
    input wire pin_level_t        mode_level_in,
    input wire logic              mode_sync_in,
    input wire pin_level_t        min_level_in,
    input wire logic              shutdown_suspend_n_in,
    input wire logic [CTL_W-1:0]  ctl_ratio_in,
    input wire logic              comm_sense_in,
    input wire logic              pwm_trip_in,
    input wire logic              cur_limit_in,
    input wire logic              avg_sense_above_in,
    input wire logic              chop_pwm_out,
    input wire logic              regulate_en_out,
    input wire cur_target_t       cur_target_out,
    input wire logic [CODE_W-1:0] code_out,
    input wire logic              high_side_out,
    input wire logic              lamp_out_flag_out
);
    // ======================================================================
    // Off-time gap counter
    // ======================================================================
    // Starts saturated so an unknown post-reset buck state cannot false-fire
    logic [7:0] off_gap_q;
    logic [7:0] off_gap_d;
    always_comb begin
        off_gap_d = off_gap_q;
        if (high_side_out) begin
            off_gap_d = 8'h00;
        end else if (ce_in && off_gap_q != 8'hff) begin
            off_gap_d = off_gap_q + 8'h01;
        end
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            off_gap_q <= 8'hff;
        end else begin
            off_gap_q <= off_gap_d;
        end
    end

    // ======================================================================
    // Properties
    // ======================================================================
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // Lamp running with a given minimum-level setting for three cycles
    sequence run_with(lvl);
        (min_level_in == lvl && shutdown_suspend_n_in && !lamp_out_flag_out) [*3];
    endsequence
    sequence min_held(lvl);
        min_level_in == lvl [*3];
    endsequence

    chk_wait_one_cycle: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out && ce_in
        |=> !avs_waitrequest_out) else $error("bus wait longer than one cycle");
    chk_rail_min_zero: assert property (min_held(LVL_RAIL) |-> cur_target_out.min_weight == WEIGHT_ZERO)
        else $error("min weight not zero with chopping off");
    chk_ref_full_cur: assert property (run_with(LVL_REF) |->
        cur_target_out.ref_weight == WEIGHT_FULL && cur_target_out.min_weight == WEIGHT_ZERO)
        else $error("current not at maximum with min at reference");
    chk_both_weight_sum: assert property (run_with(LVL_GND) |->
        {1'b0, cur_target_out.ref_weight} + {1'b0, cur_target_out.min_weight} == 7'h20)
        else $error("current weights do not sum to 32");
    chk_off_time_min: assert property ($rose(high_side_out) |-> off_gap_q >= OFF_TIME_CYC)
        else $error("high side on before off time");
    chk_trip_ends_on: assert property (high_side_out && (pwm_trip_in || cur_limit_in) && ce_in
        |=> !high_side_out) else $error("on time not ended by trip");
    chk_lamp_out_cause: assert property ($rose(lamp_out_flag_out) |-> !$past(avg_sense_above_in))
        else $error("lamp out set while sense above");
    chk_lamp_out_dark: assert property (lamp_out_flag_out [*2] |-> !chop_pwm_out)
        else $error("lamp on after lamp out");
    chk_shdn_pin_dark: assert property ((mode_level_in != LVL_RAIL && !shutdown_suspend_n_in) [*3]
        |-> !chop_pwm_out && !lamp_out_flag_out) else $error("lamp on in analog shutdown");
    chk_reg_on_only: assert property (regulate_en_out |-> chop_pwm_out)
        else $error("regulation outside on period");
endmodule : bright_chop_props

bind bright_chop_ctrl bright_chop_props #(.LAMP_OUT_CYCLES(LAMP_OUT_CYCLES)) props_u (.mclk_in, .rst_in, .ce_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .mode_level_in, .mode_sync_in, .min_level_in, .shutdown_suspend_n_in, .ctl_ratio_in,
    .comm_sense_in, .pwm_trip_in, .cur_limit_in, .avg_sense_above_in, .chop_pwm_out, .regulate_en_out,
    .cur_target_out, .code_out, .high_side_out, .lamp_out_flag_out);

// file: sim/lamp_side_model.sv
`timescale 1ns/10ps
module lamp_side_model (
    input  wire logic mclk_in,
    input  wire logic high_side_in,
    output logic      sync_out,
    output logic      sense_out,
    output logic      trip_out
);
    // ======================================================================
    // Inverter side: sync every cycle, sense falls every 32, trip after 8 on
    // ======================================================================
    logic [4:0] ph_q = 5'h00;
    logic [3:0] on_q = 4'h0;
    always_ff @(posedge mclk_in) begin
        ph_q <= ph_q + 5'h01;
        on_q <= high_side_in ? on_q + 4'h1 : 4'h0;
    end
    // Sync every cycle keeps a chopping period at 128 clocks
    assign sync_out  = 1'b1;
    assign sense_out = ph_q[4];
    assign trip_out  = (on_q >= 4'h8);
endmodule : lamp_side_model

// file: sim/test_bright_chop_ctrl.sv
`timescale 1ns/10ps
module test_bright_chop_ctrl
    import chop_pkg::*;
;
    logic mclk_in, rst_in, ce_in, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [3:0] avs_address_in, avs_byteenable_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, rd;
    pin_level_t mode_level_in, min_level_in;
    logic mode_sync_in, shutdown_suspend_n_in, comm_sense_in, pwm_trip_in, cur_limit_in, avg_sense_above_in;
    logic [CTL_W-1:0] ctl_ratio_in;
    logic chop_pwm_out, regulate_en_out, high_side_out, lamp_out_flag_out;
    cur_target_t cur_target_out;
    logic [CODE_W-1:0] code_out;
    int err_count = 0;
    int num_checks = 0;

    bright_chop_ctrl #(.LAMP_OUT_CYCLES(50)) dut_u (.mclk_in, .rst_in, .ce_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
        .mode_level_in, .mode_sync_in, .min_level_in, .shutdown_suspend_n_in, .ctl_ratio_in, .comm_sense_in,
        .pwm_trip_in, .cur_limit_in, .avg_sense_above_in, .chop_pwm_out, .regulate_en_out, .cur_target_out,
        .code_out, .high_side_out, .lamp_out_flag_out);
    lamp_side_model side_u (.mclk_in, .high_side_in(high_side_out), .sync_out(mode_sync_in),
        .sense_out(comm_sense_in), .trip_out(pwm_trip_in));

    // ======================================================================
    // Clock, watchdog and tasks
    // ======================================================================
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    // About 6k cycles of tests; about seven times that means a hang
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk_in); // Idle edge between calls
        avs_address_in <= a;
        avs_writedata_in <= wd;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        @(posedge mclk_in);
        while (avs_waitrequest_out !== 1'b0 && n < 50) begin
            @(posedge mclk_in);
            n++;
        end
        if (n == 50) check(1'b0, 1'b1);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask : bus

    // ======================================================================
    // Tests
    // ======================================================================
    pin_level_t ml[8] = '{LVL_GND, LVL_GND, LVL_GND, LVL_GND, LVL_GND, LVL_GND, LVL_RAIL, LVL_REF};
    int cd[8] = '{0, 3, 4, 16, 30, 31, 4, 4};
    pin_level_t am[12] = '{LVL_GND, LVL_GND, LVL_GND, LVL_GND, LVL_GND, LVL_GND,
                           LVL_REF, LVL_REF, LVL_REF, LVL_REF, LVL_REF, LVL_REF};
    int av[12] = '{1023, 0, 62, 63, 31, 30, 0, 1023, 961, 960, 992, 993};
    int ac[12] = '{31, 0, 0, 1, 1, 0, 31, 0, 0, 1, 1, 0};
    initial begin
        int thr, n;
        logic [5:0] rw, mw;
        {rst_in, ce_in, avs_read_in, avs_write_in, cur_limit_in} = 5'h18;
        {avs_address_in, avs_writedata_in, avs_byteenable_in, ctl_ratio_in} = '0;
        avs_byteenable_in = 4'h1;
        {mode_level_in, min_level_in} = {LVL_RAIL, LVL_GND};
        {shutdown_suspend_n_in, avg_sense_above_in} = 2'h3;
        repeat (5) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        bus(1'b0, REG_BRIGHT, 32'h0);
        check(rd, 32'h0000_001f);
        bus(1'b1, REG_STATUS, 32'h0000_0000);
        bus(1'b0, REG_STATUS, 32'h0);
        check(rd & 32'hffff_ffbf, 32'h0000_031f);
        bus(1'b0, 4'hc, 32'h0);
        check(rd, 32'h0);
        $display("test registers done");
        // Duty over two whole periods, and current weights, per code and setting
        for (int i = 0; i < 8; i++) begin
            min_level_in <= ml[i];
            bus(1'b1, REG_BRIGHT, 32'(cd[i]));
            repeat (300) @(posedge mclk_in);
            check(code_out, 32'(cd[i]));
            thr = (ml[i] == LVL_RAIL) ? 128 : (cd[i] <= 3) ? 12 : (cd[i] + 1) * 4;
            rw = (ml[i] == LVL_REF) ? 6'h20 : 6'(cd[i]);
            mw = (ml[i] == LVL_GND) ? 6'(32 - cd[i]) : 6'h00;
            check({20'h0, cur_target_out}, {20'h0, rw, mw});
            n = 0;
            repeat (256) begin
                @(posedge mclk_in);
                if (chop_pwm_out === 1'b1) n++;
            end
            check(n, 2 * thr);
        end
        $display("test duty done");
        for (int i = 0; i < 12; i++) begin
            mode_level_in <= am[i];
            ctl_ratio_in <= 10'(av[i]);
            repeat (40) @(posedge mclk_in);
            check(code_out, 32'(ac[i]));
        end
        $display("test converter done");
        shutdown_suspend_n_in <= 1'b0;
        repeat (10) @(posedge mclk_in);
        check(chop_pwm_out, 1'b0);
        bus(1'b0, REG_STATUS, 32'h0);
        check(rd & 32'h480, 32'h080);
        mode_level_in <= LVL_RAIL;
        bus(1'b0, REG_STATUS, 32'h0);
        check(rd & 32'h780, 32'h700);
        shutdown_suspend_n_in <= 1'b1;
        min_level_in <= LVL_RAIL;
        $display("test shutdown done");
        n = 0;
        repeat (500) begin
            @(posedge mclk_in);
            if (high_side_out === 1'b1 && pwm_trip_in === 1'b0 && n == 0) n = 1;
        end
        check(n, 1);
        cur_limit_in <= 1'b1;
        repeat (300) @(posedge mclk_in);
        cur_limit_in <= 1'b0;
        $display("test buck done");
        avg_sense_above_in <= 1'b0;
        repeat (40) @(posedge mclk_in);
        check(lamp_out_flag_out, 1'b0);
        repeat (20) @(posedge mclk_in);
        check({lamp_out_flag_out, chop_pwm_out}, 2'h2);
        avg_sense_above_in <= 1'b1;
        bus(1'b1, REG_CTRL, 32'h0000_0002);
        @(posedge mclk_in);
        @(posedge mclk_in);
        check(lamp_out_flag_out, 1'b0);
        $display("test lamp out done");
        print_verdict();
    end
endmodule : test_bright_chop_ctrl
